// file: hw/dfc_ctrl_regs.vh
`ifndef DFC_CTRL_REGS_VH
`define DFC_CTRL_REGS_VH

// Subaddresses
`define DFC_SUB_SILICON_REV    8'h00
`define DFC_SUB_STEP_DELAY     8'h01
`define DFC_SUB_INPUT_CTRL     8'h02

// Reset values
`define DFC_STEP_DELAY_RESET   8'h07
`define DFC_INPUT_CTRL_RESET   8'h00

// Field positions, subaddress 00h
`define DFC_REV_MSB            7
`define DFC_REV_LSB            4

// Field positions, subaddress 01h
`define DFC_PWL_DISABLE_BIT    6
`define DFC_HYST_MSB           5
`define DFC_HYST_LSB           4
`define DFC_STEP_MSB           3
`define DFC_STEP_LSB           0

// Field positions, subaddress 02h
`define DFC_FES_MSB            7
`define DFC_FES_LSB            6
`define DFC_MODE_MSB           5
`define DFC_MODE_LSB           0

// Codes
`define DFC_STEP_FREEZE        4'hf
`define DFC_STEP_MAX_TAP       4'he
`define DFC_FES_AMP_ONLY       2'h2
`define DFC_FES_AMP_FILTER     2'h3
`define DFC_MODE_LAST_CVBS     6'h05

// Nominal luminance white level
`define DFC_WHITE_LEVEL        8'heb

`endif

// file: hw/dfc_gain_hyst.v
`timescale 1ns/100ps
`default_nettype none

module dfc_gain_hyst #(
   parameter GAIN_W = 9
) (
   // Clock and reset
   input  wire              clk_sys,
   input  wire              rst_n,
   // Gain request
   input  wire [GAIN_W-1:0] gain_target,
   input  wire              gain_target_valid,
   input  wire [1:0]        hyst_sel,
   // Applied gain
   output reg  [GAIN_W-1:0] gain_out
);

   reg  [GAIN_W-1:0] diff;

   always @* begin
      if (gain_target > gain_out) begin
         diff = gain_target - gain_out;
      end else begin
         diff = gain_out - gain_target;
      end
   end

   // Small wobble in the loop is swallowed, so the gain does not dither
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         gain_out <= {GAIN_W{1'b0}};
      end else if (gain_target_valid && (diff > {{(GAIN_W-2){1'b0}}, hyst_sel})) begin
         gain_out <= gain_target; // [RL7]
      end
   end

endmodule

`default_nettype wire

// file: hw/dfc_ctrl_top.v
`timescale 1ns/100ps
`default_nettype none
`include "dfc_ctrl_regs.vh"

// Summary of operation
// RL1: Host writes zero to unused bits.
// RL2: Subaddress 00h upper nibble shows revision, read-only.
// RL3: Step delay aligns horizontal timing to converter.
// RL4: Delay code 1111 freezes, 1110 min, 0000 max.
// RL5: Host should program delay code 0111 only.
// RL6: Bit 6 low limits luma above white.
// RL7: Bits 5:4 set gain hysteresis zero to three.
// RL8: Host avoids noise reduction with limiting on.
// RL9: Bits 7:6 select amplifier and anti-alias filter.
// RL10: Modes 0 to 5 pick composite inputs.
// RL11: Registers hold writes, read back stored value.
module dfc_ctrl_top #(
   parameter [6:0] DEV_ADDR     = 7'h21,
   parameter [3:0] SILICON_REV  = 4'h1,
   parameter       GAIN_W       = 9
) (
   // Clock and reset
   input  wire              clk_sys,
   input  wire              rst_n,
   // Two-wire serial bus
   input  wire              scl_in,
   input  wire              sda_in,
   output wire              sda_out,
   output wire              sda_oe,
   // Horizontal step timing
   input  wire              h_step_in,
   output reg               h_step_out,
   // Luminance path
   input  wire [7:0]        luma_in,
   input  wire              luma_valid,
   output reg  [7:0]        luma_out,
   output reg               white_limit_active,
   // Gain loop
   input  wire [GAIN_W-1:0] gain_target,
   input  wire              gain_target_valid,
   output wire [GAIN_W-1:0] gain_out,
   // Analog front end
   output reg               amp_enable,
   output reg               alias_filter_enable,
   output reg               agc_enable,
   output reg  [5:0]        analog_input_sel
);

   // Bus states
   localparam [6:0] ST_IDLE = 7'h01;
   localparam [6:0] ST_ADDR = 7'h02;
   localparam [6:0] ST_SUB  = 7'h04;
   localparam [6:0] ST_WR   = 7'h08;
   localparam [6:0] ST_RD   = 7'h10;
   localparam [6:0] ST_SKIP = 7'h20;
   localparam [6:0] ST_HOLD = 7'h40;

   reg  [6:0]  state_reg;
   reg  [3:0]  bit_cnt_reg;
   reg  [7:0]  shift_reg;
   reg  [7:0]  tx_reg;
   reg  [7:0]  sub_ptr_reg;
   reg         rw_reg;
   reg         ack_drv_reg;
   reg         nack_reg;
   reg  [7:0]  step_delay_reg;
   reg  [7:0]  input_ctrl_reg;
   reg         scl_s1;
   reg         scl_s2;
   reg         scl_d;
   reg         sda_s1;
   reg         sda_s2;
   reg         sda_d;
   reg  [14:0] step_line_reg;

   wire        scl_rise;
   wire        scl_fall;
   wire        bus_start;
   wire        bus_stop;
   wire [3:0]  step_code;
   wire [1:0]  fes_code;
   wire [5:0]  mode_code;
   wire [7:0]  luma_excess;

   function [7:0] read_mux;
      input [7:0] sub;
      begin
         case (sub)
            `DFC_SUB_SILICON_REV: read_mux = {SILICON_REV, 4'h0}; // [RL2]
            `DFC_SUB_STEP_DELAY:  read_mux = step_delay_reg; // [RL11]
            `DFC_SUB_INPUT_CTRL:  read_mux = input_ctrl_reg; // [RL11]
            default:              read_mux = 8'h00;
         endcase
      end
   endfunction

   // Pins are asynchronous to clk_sys
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d  <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d  <= 1'b1;
      end else begin
         scl_s1 <= scl_in;
         scl_s2 <= scl_s1;
         scl_d  <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_d  <= sda_s2;
      end
   end

   assign scl_rise  = scl_s2 & ~scl_d;
   assign scl_fall  = ~scl_s2 & scl_d;
   assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign bus_stop  = scl_s2 & scl_d & ~sda_d & sda_s2;

   // Open drain: only ever pull low
   assign sda_out = 1'b0;
   // Last read bit stands until SCL falls; an early release would look like a STOP
   assign sda_oe  = ack_drv_reg | ((state_reg == ST_RD) && (bit_cnt_reg < 4'd9) && !tx_reg[7]);

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg      <= ST_IDLE;
         bit_cnt_reg    <= 4'h0;
         shift_reg      <= 8'h00;
         tx_reg         <= 8'hff;
         sub_ptr_reg    <= 8'h00;
         rw_reg         <= 1'b0;
         ack_drv_reg    <= 1'b0;
         nack_reg       <= 1'b0;
         step_delay_reg <= `DFC_STEP_DELAY_RESET;
         input_ctrl_reg <= `DFC_INPUT_CTRL_RESET;
      end else if (bus_start) begin
         state_reg   <= ST_ADDR;
         bit_cnt_reg <= 4'h0;
         ack_drv_reg <= 1'b0;
         tx_reg      <= 8'hff;
      end else if (bus_stop) begin
         state_reg   <= ST_IDLE;
         ack_drv_reg <= 1'b0;
         tx_reg      <= 8'hff;
      end else if (scl_rise && !(state_reg == ST_IDLE)) begin
         if (bit_cnt_reg < 4'd8) begin
            shift_reg   <= {shift_reg[6:0], sda_s2};
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
         end else if (bit_cnt_reg == 4'd8) begin
            nack_reg    <= sda_s2;
            bit_cnt_reg <= 4'd9;
         end
      end else if (scl_fall) begin
         case (state_reg)
            ST_IDLE: begin
               ack_drv_reg <= 1'b0;
            end
            ST_ADDR, ST_SUB, ST_WR: begin
               if (bit_cnt_reg == 4'd8) begin
                  ack_drv_reg <= 1'b1;
                  if (state_reg == ST_ADDR) begin
                     rw_reg <= shift_reg[0];
                     if (shift_reg[7:1] != DEV_ADDR) begin
                        ack_drv_reg <= 1'b0;
                        state_reg   <= ST_SKIP;
                     end
                  end else if (state_reg == ST_SUB) begin
                     sub_ptr_reg <= shift_reg;
                  end else begin
                     // Unmapped and read-only subaddresses drop the data
                     if (sub_ptr_reg == `DFC_SUB_STEP_DELAY) begin
                        step_delay_reg <= shift_reg; // [RL11]
                     end
                     if (sub_ptr_reg == `DFC_SUB_INPUT_CTRL) begin
                        input_ctrl_reg <= shift_reg; // [RL11]
                     end
                     sub_ptr_reg <= sub_ptr_reg + 8'd1;
                  end
               end else if (bit_cnt_reg == 4'd9) begin
                  ack_drv_reg <= 1'b0;
                  bit_cnt_reg <= 4'h0;
                  if (state_reg == ST_ADDR) begin
                     if (rw_reg) begin
                        state_reg <= ST_RD;
                        tx_reg    <= read_mux(sub_ptr_reg);
                     end else begin
                        state_reg <= ST_SUB;
                     end
                  end else begin
                     state_reg <= ST_WR;
                  end
               end
            end
            ST_RD: begin
               if ((bit_cnt_reg > 4'd0) && (bit_cnt_reg < 4'd8)) begin
                  tx_reg <= {tx_reg[6:0], 1'b1};
               end else if (bit_cnt_reg == 4'd8) begin
                  tx_reg      <= 8'hff;
                  sub_ptr_reg <= sub_ptr_reg + 8'd1;
               end else if (bit_cnt_reg == 4'd9) begin
                  bit_cnt_reg <= 4'h0;
                  if (nack_reg) begin
                     state_reg <= ST_HOLD;
                  end else begin
                     tx_reg <= read_mux(sub_ptr_reg);
                  end
               end
            end
            ST_SKIP, ST_HOLD: begin
               ack_drv_reg <= 1'b0;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   assign step_code   = step_delay_reg[`DFC_STEP_MSB:`DFC_STEP_LSB];
   assign fes_code    = input_ctrl_reg[`DFC_FES_MSB:`DFC_FES_LSB];
   assign mode_code   = input_ctrl_reg[`DFC_MODE_MSB:`DFC_MODE_LSB];
   assign luma_excess = luma_in - `DFC_WHITE_LEVEL;

   // Delay is 16 minus code cycles; a tap line avoids a counter per pulse
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         step_line_reg <= 15'h0000;
         h_step_out    <= 1'b0;
      end else begin
         step_line_reg <= {step_line_reg[13:0], h_step_in}; // [RL3]
         if (step_code == `DFC_STEP_FREEZE) begin
            h_step_out <= 1'b0; // [RL4]
         end else begin
            h_step_out <= step_line_reg[`DFC_STEP_MAX_TAP - step_code]; // [RL4]
         end
      end
   end

   // Excess above white is halved rather than clipped, keeping some detail
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         luma_out           <= 8'h00;
         white_limit_active <= 1'b0;
      end else if (luma_valid) begin
         if (!step_delay_reg[`DFC_PWL_DISABLE_BIT] && (luma_in > `DFC_WHITE_LEVEL)) begin
            luma_out           <= `DFC_WHITE_LEVEL + {1'b0, luma_excess[7:1]}; // [RL6]
            white_limit_active <= 1'b1;
         end else begin
            luma_out           <= luma_in; // [RL6]
            white_limit_active <= 1'b0;
         end
      end
   end

   // Code 01 is undefined; treated as full bypass
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         amp_enable          <= 1'b0;
         alias_filter_enable <= 1'b0;
         agc_enable          <= 1'b0;
         analog_input_sel    <= 6'h00;
      end else begin
         amp_enable          <= (fes_code == `DFC_FES_AMP_ONLY) ||
                                (fes_code == `DFC_FES_AMP_FILTER); // [RL9]
         alias_filter_enable <= (fes_code == `DFC_FES_AMP_FILTER); // [RL9]
         if (mode_code <= `DFC_MODE_LAST_CVBS) begin
            analog_input_sel <= 6'h01 << mode_code[2:0]; // [RL10]
            agc_enable       <= 1'b1; // [RL10]
         end else begin
            analog_input_sel <= 6'h00;
            agc_enable       <= 1'b0;
         end
      end
   end

   dfc_gain_hyst #(
      .GAIN_W (GAIN_W)
   ) u_gain_hyst (
      .clk_sys           (clk_sys),
      .rst_n             (rst_n),
      .gain_target       (gain_target),
      .gain_target_valid (gain_target_valid),
      .hyst_sel          (step_delay_reg[`DFC_HYST_MSB:`DFC_HYST_LSB]),
      .gain_out          (gain_out)
   );

endmodule

`default_nettype wire

// file: testbench/dfc_ctrl_props.sv
`timescale 1ns/100ps
`default_nettype none
module dfc_ctrl_props #(
   parameter GAIN_W = 9
) (
   // Clock and reset
   input wire logic              clk_sys,
   input wire logic              rst_n,
   // Luminance path
   input wire logic [7:0]        luma_in,
   input wire logic              luma_valid,
   input wire logic [7:0]        luma_out,
   input wire logic              white_limit_active,
   // Gain loop
   input wire logic [GAIN_W-1:0] gain_target,
   input wire logic              gain_target_valid,
   input wire logic [GAIN_W-1:0] gain_out,
   // Analog front end
   input wire logic              amp_enable,
   input wire logic              alias_filter_enable,
   input wire logic              agc_enable,
   input wire logic [5:0]        analog_input_sel
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   chk_filter_needs_amp: assert property (
      alias_filter_enable |-> amp_enable) else $error("filter on without amplifier");
   chk_input_one_hot: assert property (
      agc_enable == (analog_input_sel != 6'h00) && $onehot0(analog_input_sel))
      else $error("input select not one-hot with gain");
   chk_luma_holds: assert property (
      !luma_valid |=> $stable(luma_out)) else $error("luma changed without valid");
   chk_luma_below_white: assert property (
      luma_valid && luma_in <= 8'heb |=> luma_out == $past(luma_in) && !white_limit_active)
      else $error("luma below white altered");
   chk_luma_limit_range: assert property (
      luma_valid ##1 white_limit_active |-> luma_out >= 8'heb && luma_out <= 8'hf5
      && $past(luma_in) > luma_out) else $error("limited luma out of range");
   chk_gain_holds: assert property (
      !gain_target_valid |=> $stable(gain_out)) else $error("gain changed without valid");
   chk_gain_from_target: assert property (
      gain_target_valid ##1 $changed(gain_out) |-> gain_out == $past(gain_target))
      else $error("gain moved to other value");
   chk_gain_big_step: assert property (
      gain_target_valid && ({1'b0, gain_target} > {1'b0, gain_out} + 3
      || {1'b0, gain_out} > {1'b0, gain_target} + 3) |=> gain_out == $past(gain_target))
      else $error("large gain step not applied");
endmodule
`default_nettype wire

// file: testbench/dfc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module dfc_host_model #(
   parameter [6:0] DEV_ADDR = 7'h21
) (
   // Bus pins
   output logic      scl,
   output logic      sda_drv_low,
   input  wire logic sda
);
   localparam time PH = 200;
   initial begin
      scl = 1'b1;
      sda_drv_low = 1'b0;
   end
   // Data moves mid-low phase, well clear of both clock edges
   task automatic bit_io(input logic b, output logic r);
      #PH sda_drv_low = !b;
      #PH scl = 1'b1;
      #PH r = sda;
      scl = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(1'b1, a);
   endtask
   task automatic start;
      #PH sda_drv_low = 1'b0;
      #PH scl = 1'b1;
      #PH sda_drv_low = 1'b1;
      #PH scl = 1'b0;
   endtask
   task automatic stop;
      #PH sda_drv_low = 1'b1;
      #PH scl = 1'b1;
      #PH sda_drv_low = 1'b0;
      #PH;
   endtask
   task automatic wr(input logic [7:0] s, input logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic a0, a1, a2;
      start();
      xfer({DEV_ADDR, 1'b0}, q, a0);
      xfer(s, q, a1);
      xfer(d, q, a2);
      stop();
      ok = !(a0 | a1 | a2);
   endtask
   // Single byte read ends with a not-acknowledge
   task automatic rd(input logic [7:0] s, output logic [7:0] v);
      logic a;
      start();
      xfer({DEV_ADDR, 1'b0}, v, a);
      xfer(s, v, a);
      start();
      xfer({DEV_ADDR, 1'b1}, v, a);
      xfer(8'hff, v, a);
      stop();
   endtask
endmodule
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
bind dfc_ctrl_top dfc_ctrl_props #(.GAIN_W(GAIN_W)) u_props (.clk_sys(clk_sys),
   .rst_n(rst_n), .luma_in(luma_in), .luma_valid(luma_valid), .luma_out(luma_out),
   .white_limit_active(white_limit_active), .gain_target(gain_target),
   .gain_target_valid(gain_target_valid), .gain_out(gain_out), .amp_enable(amp_enable),
   .alias_filter_enable(alias_filter_enable), .agc_enable(agc_enable),
   .analog_input_sel(analog_input_sel));
module tb;
   logic       clk_sys = 0, rst_n = 0, h_step_in = 0, luma_valid = 0, gain_target_valid = 0;
   logic       scl, host_low, sda_oe, sda_out, h_step_out, white_limit_active;
   logic       amp_enable, alias_filter_enable, agc_enable;
   logic [7:0] luma_in = 0, luma_out;
   logic [8:0] gain_target = 0, gain_out;
   logic [5:0] analog_input_sel;
   int         errors = 0, checked = 0, cycles = 0;
   wire        sda = !(host_low | (sda_oe & !sda_out));
   // Revision value is arbitrary
   dfc_ctrl_top #(.SILICON_REV(4'h5)) u_dut (.clk_sys, .rst_n, .scl_in(scl), .sda_in(sda),
      .sda_out, .sda_oe, .h_step_in, .h_step_out, .luma_in, .luma_valid, .luma_out,
      .white_limit_active, .gain_target, .gain_target_valid, .gain_out, .amp_enable,
      .alias_filter_enable, .agc_enable, .analog_input_sel);
   dfc_host_model h (.scl(scl), .sda_drv_low(host_low), .sda(sda));
   always #12.5 clk_sys = !clk_sys;
   // Whole run needs about 22.5k cycles; over two and a half times that means a hang
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         close_out();
      end
   end
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic cyc(int n = 1);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(logic [7:0] s, logic [7:0] d);
      logic ok;
      h.wr(s, d, ok);
      check("ack", ok, 1'b1);
      cyc(2);
   endtask
   task automatic rd(logic [7:0] s, logic [7:0] e);
      logic [7:0] v;
      h.rd(s, v);
      check("readback", v, e);
   endtask
   task automatic t_reset;
      check("amp", amp_enable, 1'b0);
      check("agc", agc_enable, 1'b1);
      check("sel", analog_input_sel, 6'h01);
      rd(8'h00, 8'h50);
      rd(8'h01, 8'h07);
      wr(8'h00, 8'hff);
      rd(8'h00, 8'h50);
      $display("done reset and revision");
   endtask
   task automatic t_front;
      for (int f = 0; f < 7; f++) begin
         wr(8'h02, {f[1:0], 3'h0, f[2:0]});
         check("amp", amp_enable, f[1]);
         check("filter", alias_filter_enable, f[1:0] == 2'h3);
         check("sel", analog_input_sel, f < 6 ? 6'h01 << f : 6'h00);
         check("agc", agc_enable, f < 6);
         rd(8'h02, {f[1:0], 3'h0, f[2:0]});
      end
      $display("done front end and modes");
   endtask
   task automatic t_step;
      logic [3:0] codes [4] = '{4'h7, 4'he, 4'h0, 4'hf};
      int n;
      foreach (codes[i]) begin
         wr(8'h01, {4'h4, codes[i]});
         h_step_in = 1;
         cyc();
         h_step_in = 0;
         n = 1;
         while (!h_step_out && n < 20) begin
            cyc();
            n++;
         end
         check("step delay", n, codes[i] == 4'hf ? 20 : 16 - codes[i]);
      end
      $display("done step delay");
   endtask
   task automatic t_white;
      for (int w = 0; w < 2; w++) begin
         wr(8'h01, {1'b0, w[0], 6'h07});
         luma_in = 8'hff;
         luma_valid = 1;
         cyc();
         luma_in = 8'heb;
         check("luma", luma_out, w ? 8'hff : 8'hf5);
         check("limit", white_limit_active, !w);
         cyc();
         luma_valid = 0;
         check("luma white", luma_out, 8'heb);
      end
      $display("done white limit");
   endtask
   task automatic t_hyst;
      logic [8:0] g = 9'h040;
      gain_target = g;
      gain_target_valid = 1;
      for (int k = 0; k < 4; k++) begin
         wr(8'h01, {2'b01, k[1:0], 4'h7});
         gain_target = g + k;
         cyc();
         check("gain hold", gain_out, g);
         g = g + k + 1;
         gain_target = g;
         cyc();
         check("gain move", gain_out, g);
      end
      gain_target_valid = 0;
      $display("done gain hysteresis");
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      #1 rst_n = 1;
      cyc(4);
      t_reset();
      t_front();
      t_step();
      t_white();
      t_hyst();
      close_out();
   end
endmodule
`default_nettype wire
